// *** hdl/psel_cfg.svh ***
`ifndef PSEL_CFG_SVH
`define PSEL_CFG_SVH

`define PSEL_MAX_SETS 4
`define PSEL_PW_DEFAULT 16

// register byte offsets, one aligned word each
`define PSEL_OFS_CTRL 8'h00
`define PSEL_OFS_COUNT 8'h04
`define PSEL_OFS_LSRC 8'h08
`define PSEL_OFS_INVERT 8'h0C
`define PSEL_OFS_SLOT 8'h10
`define PSEL_OFS_STORE 8'h14
`define PSEL_OFS_ACTIVE 8'h18
`define PSEL_OFS_STATUS 8'h1C

// field positions
`define PSEL_CTRL_ON_BIT 0
`define PSEL_CTRL_POLICY_BIT 1
`define PSEL_LSRC_PICK_BIT 0
`define PSEL_LSRC_LINE_BIT 1
`define PSEL_STORE_GO_BIT 0

// set count values: reset, minimum, two
`define PSEL_COUNT_RST 3'h4
`define PSEL_COUNT_MIN 3'h1
`define PSEL_COUNT_TWO 3'h2

// line settling window after any address line change
`define PSEL_CLK_PERIOD_NS 50
`define PSEL_SETTLE_NS 1000
`define PSEL_SETTLE_CYC ((`PSEL_SETTLE_NS + `PSEL_CLK_PERIOD_NS - 1) / `PSEL_CLK_PERIOD_NS)

`endif

// *** hdl/psel_pkg.sv ***
package psel_pkg;

  typedef enum logic [2:0] {
    PSEL_OFF = 3'h0,
    PSEL_WAIT = 3'h1,
    PSEL_LOAD = 3'h3,
    PSEL_FRAME = 3'h2,
    PSEL_RESTORE = 3'h6
  } psel_state_e;

  typedef logic [1:0] psel_addr_t;

endpackage

// *** hdl/psel_line_if.sv ***
`timescale 1ns/1ps
interface psel_line_if;
  logic [1:0] lines;
  logic quiet;
  modport src (output lines, output quiet);
  modport dst (input lines, input quiet);
endinterface

// *** hdl/psel_sync.sv ***
`timescale 1ns/1ps
module psel_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  generate
    if (W < 1)
    begin : g_bad
      $error("psel_sync: W must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

// *** hdl/psel_settle.sv ***
`timescale 1ns/1ps
module psel_settle #(
  parameter int SETTLE_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] lines_i,
  psel_line_if.src lo
);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam logic [CW-1:0] LOAD_V = CW'(SETTLE_CYC);

  logic [1:0] prev_reg;
  logic [CW-1:0] cnt_reg;
  logic change;

  generate
    if (SETTLE_CYC < 1)
    begin : g_bad
      $error("psel_settle: SETTLE_CYC must be at least 1");
    end
  endgenerate

  assign change = (lines_i != prev_reg);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_reg <= 2'h0;
    else
      prev_reg <= lines_i;
  end

  // the window restarts on every edge, so a bouncing line keeps triggers shut out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_reg <= '0;
    else if (change)
      cnt_reg <= LOAD_V; // R18
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - CW'(1);
  end

  assign lo.lines = lines_i;
  assign lo.quiet = ~change & (cnt_reg == '0); // R18
endmodule

// *** hdl/psel_top.sv ***
// Function
// (R1) stored sets are numbered from zero, four sets at most, indices 0 to 3
// (R2) set address is the binary index, bit 1 most significant
// (R3) set count fixes available sets and the number of address bits used
// (R4) with two sets only address bit 0 is used, 0 picks set 0, 1 set 1
// (R5) with two sets either line 1 or line 2 may drive bit 0
// (R6) a non-inverted line reads high as 1 and low as 0
// (R7) an inverted line reads low as 1 and high as 0
// (R8) with more than two sets both address bits are used
// (R9) two bits: line 1 drives bit 0 and line 2 bit 1, or swapped
// (R10) software disables sequencing before changing policy, count, sources or sets
// (R11) software selects the line-chosen advance policy
// (R12) set count above four is refused
// (R13) with two sets bit 0 is the picked address bit by default
// (R14) software gives bit 1 the line not used by bit 0
// (R15) slot pointer takes values 0 through 3
// (R16) store command copies the whole active set into the pointed slot
// (R17) each accepted trigger samples lines and loads the addressed set as active
// (R18) while a line changes, waiting status drops and triggers are ignored
// (R19) on disable the running frame ends, then pre-sequencing values return
// (R20) the set is loaded before the exposure of the same trigger starts
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "psel_cfg.svh"
module psel_top #(
  parameter int PW = `PSEL_PW_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line1_i,
  input wire logic line2_i,
  input wire logic frame_trig_i,
  input wire logic frame_done_i,
  output logic [PW-1:0] active_set_o,
  output logic [1:0] set_index_o,
  output logic exposure_start_o,
  output logic waiting_trig_o
);
  localparam int NSETS = `PSEL_MAX_SETS;

  generate
    if (PW < 1 || PW > 32)
    begin : g_bad
      $error("psel_top: PW must be 1..32");
    end
  endgenerate

  logic [2:0] sync_q;
  logic trig_d_reg;
  logic trig_edge;
  psel_line_if lif();

  psel_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({frame_trig_i, line2_i, line1_i}),
    .q_o(sync_q)
  );

  psel_settle #(.SETTLE_CYC(`PSEL_SETTLE_CYC)) u_settle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lines_i(sync_q[1:0]),
    .lo(lif.src)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trig_d_reg <= 1'b0;
    else
      trig_d_reg <= sync_q[2];
  end

  assign trig_edge = sync_q[2] & ~trig_d_reg;

  // configuration and state
  logic seq_on_reg;
  logic policy_reg;
  logic [2:0] count_reg;
  logic pick_reg;
  logic [1:0] src_reg;
  logic [1:0] inv_reg;
  psel_pkg::psel_addr_t slot_ptr_reg;
  logic [PW-1:0] active_reg;
  logic [PW-1:0] pre_seq_reg;
  logic [PW-1:0] slot_mem [NSETS];
  psel_pkg::psel_state_e state_reg;
  psel_pkg::psel_addr_t cur_idx_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // bus decode
  logic wb_req;
  logic wr0;
  logic [31:0] wmask;
  logic [31:0] act_merge;
  logic count_ok;
  logic store_go;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr0 = wb_req & wb_we_i & wb_sel_i[0];
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign act_merge = (32'(active_reg) & ~wmask) | (wb_dat_i & wmask);
  assign count_ok = (wb_dat_i[31:3] == 29'h0) && (wb_dat_i[2:0] >= `PSEL_COUNT_MIN)
    && (wb_dat_i[2:0] <= 3'(NSETS)); // R12
  assign store_go = wr0 && (wb_adr_i == `PSEL_OFS_STORE) && wb_dat_i[`PSEL_STORE_GO_BIT];

  // address forming from the settled lines
  logic b0;
  logic b1;
  psel_pkg::psel_addr_t addr_raw;
  psel_pkg::psel_addr_t addr_sel;

  always_comb
  begin
    b0 = (src_reg[0] ? lif.lines[1] : lif.lines[0]) ^ inv_reg[src_reg[0]]; // R5 R6 R7
    b1 = (src_reg[1] ? lif.lines[1] : lif.lines[0]) ^ inv_reg[src_reg[1]]; // R9 R6 R7
    if (count_reg > `PSEL_COUNT_TWO)
      addr_raw = {b1, b0}; // R8 R2
    else if (count_reg == `PSEL_COUNT_TWO)
      addr_raw = {1'b0, b0}; // R4
    else
      addr_raw = 2'h0; // R3
    // an address past the configured count falls back to set 0
    if ({1'b0, addr_raw} < count_reg)
      addr_sel = addr_raw; // R3 R1
    else
      addr_sel = 2'h0;
  end

  logic take;
  assign take = (state_reg == psel_pkg::PSEL_WAIT) & seq_on_reg & policy_reg
    & trig_edge & lif.quiet; // R17 R18

  // wishbone answer: one registered cycle, unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_req;
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    case (wb_adr_i)
      `PSEL_OFS_CTRL: rd_mux = {30'h0, policy_reg, seq_on_reg};
      `PSEL_OFS_COUNT: rd_mux = {29'h0, count_reg};
      `PSEL_OFS_LSRC: rd_mux = {30'h0, src_reg[pick_reg], pick_reg};
      `PSEL_OFS_INVERT: rd_mux = {30'h0, inv_reg};
      `PSEL_OFS_SLOT: rd_mux = {30'h0, slot_ptr_reg};
      `PSEL_OFS_ACTIVE: rd_mux = 32'(active_reg);
      `PSEL_OFS_STATUS: rd_mux = {26'h0, state_reg, cur_idx_reg, waiting_trig_o};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (wb_req)
      rdata_reg <= rd_mux;
  end

  // control bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_on_reg <= 1'b0;
      policy_reg <= 1'b0;
    end
    else if (wr0 && wb_adr_i == `PSEL_OFS_CTRL)
    begin
      seq_on_reg <= wb_dat_i[`PSEL_CTRL_ON_BIT];
      policy_reg <= wb_dat_i[`PSEL_CTRL_POLICY_BIT];
    end
  end

  // an out-of-range count is dropped and the old count stays
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= `PSEL_COUNT_RST;
    else if (wr0 && wb_adr_i == `PSEL_OFS_COUNT && count_ok)
      count_reg <= wb_dat_i[2:0]; // R12 R3
  end

  // address bit sources
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pick_reg <= 1'b0;
      src_reg <= 2'b10;
    end
    else if (wr0 && wb_adr_i == `PSEL_OFS_COUNT && count_ok && wb_dat_i[2:0] <= `PSEL_COUNT_TWO)
      pick_reg <= 1'b0; // R13
    else if (wr0 && wb_adr_i == `PSEL_OFS_LSRC)
    begin
      if (count_reg <= `PSEL_COUNT_TWO)
      begin
        pick_reg <= 1'b0; // R13
        src_reg[0] <= wb_dat_i[`PSEL_LSRC_LINE_BIT]; // R5
      end
      else
      begin
        pick_reg <= wb_dat_i[`PSEL_LSRC_PICK_BIT];
        src_reg[wb_dat_i[`PSEL_LSRC_PICK_BIT]] <= wb_dat_i[`PSEL_LSRC_LINE_BIT]; // R9
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      inv_reg <= 2'h0;
    else if (wr0 && wb_adr_i == `PSEL_OFS_INVERT)
      inv_reg <= wb_dat_i[1:0]; // R7
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      slot_ptr_reg <= 2'h0;
    else if (wr0 && wb_adr_i == `PSEL_OFS_SLOT)
      slot_ptr_reg <= wb_dat_i[1:0]; // R15
  end

  // slot contents have no reset; software fills them before use
  always_ff @(posedge clk_i)
  begin
    if (store_go)
      slot_mem[slot_ptr_reg] <= active_reg; // R16
  end

  // the sequencer owns the active set over a bus write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      active_reg <= '0;
    else if (take)
      active_reg <= slot_mem[addr_sel]; // R17 R20
    else if (state_reg == psel_pkg::PSEL_RESTORE)
      active_reg <= pre_seq_reg; // R19
    else if (wb_req && wb_we_i && wb_adr_i == `PSEL_OFS_ACTIVE)
      active_reg <= act_merge[PW-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_seq_reg <= '0;
    else if (state_reg == psel_pkg::PSEL_OFF && seq_on_reg)
      pre_seq_reg <= active_reg; // R19
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cur_idx_reg <= 2'h0;
    else if (take)
      cur_idx_reg <= addr_sel; // R17
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= psel_pkg::PSEL_OFF;
    else
    begin
      case (state_reg)
        psel_pkg::PSEL_OFF:
          if (seq_on_reg)
            state_reg <= psel_pkg::PSEL_WAIT;
        psel_pkg::PSEL_WAIT:
          if (!seq_on_reg)
            state_reg <= psel_pkg::PSEL_RESTORE;
          else if (take)
            state_reg <= psel_pkg::PSEL_LOAD;
        psel_pkg::PSEL_LOAD:
          state_reg <= psel_pkg::PSEL_FRAME;
        psel_pkg::PSEL_FRAME:
          if (frame_done_i)
            state_reg <= seq_on_reg ? psel_pkg::PSEL_WAIT : psel_pkg::PSEL_RESTORE; // R19
        psel_pkg::PSEL_RESTORE:
          state_reg <= psel_pkg::PSEL_OFF;
        default:
          state_reg <= psel_pkg::PSEL_OFF;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign active_set_o = active_reg;
  assign set_index_o = cur_idx_reg;
  assign exposure_start_o = (state_reg == psel_pkg::PSEL_LOAD); // R20
  assign waiting_trig_o = (state_reg == psel_pkg::PSEL_WAIT) & lif.quiet; // R18

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [PW-1:0] slot_pick;
  assign slot_pick = slot_mem[addr_sel];

  sequence s_frame_ends_off;
    (state_reg == psel_pkg::PSEL_FRAME) && !seq_on_reg && frame_done_i;
  endsequence

  sequence s_restore_then_off;
    (state_reg == psel_pkg::PSEL_RESTORE) ##1
    ((state_reg == psel_pkg::PSEL_OFF) && (active_reg == pre_seq_reg));
  endsequence

  a_load_addressed_set: assert property (take |=> (active_reg == $past(slot_pick)) // R17
    && (set_index_o == $past(addr_sel)))
    else $error("addressed set not loaded on trigger");
  a_count_one_zero: assert property ((count_reg == 3'h1) |-> (addr_sel == 2'h0)) // R3
    else $error("single set count must give address zero");
  a_two_sets_line2: assert property ((count_reg == 3'h2) && src_reg[0] && !inv_reg[1] // R5
    |-> (addr_sel == {1'b0, lif.lines[1]}))
    else $error("two sets from line 2 addressed wrongly");
  a_invert_bit0: assert property ((count_reg == 3'h2) && !src_reg[0] && inv_reg[0] // R7
    |-> (addr_sel == {1'b0, ~lif.lines[0]}))
    else $error("inverted line not read as inverse");
  a_swap_two_bits: assert property ((count_reg == 3'h4) && (src_reg == 2'b01) && (inv_reg == 2'h0) // R9
    |-> (addr_sel == {lif.lines[0], lif.lines[1]}))
    else $error("swapped two bit address wrong");
  a_count_range: assert property ((count_reg >= 3'h1) && (count_reg <= 3'h4)) // R12
    else $error("set count outside 1..4");
  a_pick_default: assert property ((count_reg <= 3'h2) |-> !pick_reg) // R13
    else $error("bit 0 not picked with two sets");
  a_store_copy: assert property (store_go |=> (slot_mem[$past(slot_ptr_reg)] == $past(active_reg))) // R16
    else $error("store did not copy active set");
  a_busy_ignores: assert property ((state_reg == psel_pkg::PSEL_WAIT) && seq_on_reg && trig_edge // R18
    && !lif.quiet |=> (state_reg == psel_pkg::PSEL_WAIT) && $stable(active_reg))
    else $error("trigger taken while a line settles");
  a_change_not_wait: assert property ((lif.lines != $past(lif.lines)) |-> !waiting_trig_o) // R18
    else $error("waiting status shown during line change");
  a_restore_after: assert property (s_frame_ends_off |=> s_restore_then_off) // R19
    else $error("values not restored after last frame");
  a_load_before_expo: assert property (exposure_start_o |-> $past(take) // R20
    && (active_set_o == $past(slot_pick)))
    else $error("exposure started before set load");
endmodule

// *** bench/psel_ctl_model.sv ***
`timescale 1ns/1ps
module psel_ctl_model (
  input wire logic clk_i,
  output logic line1_o,
  output logic line2_o,
  output logic trig_o
);
  initial
  begin
    line1_o = 1'h0;
    line2_o = 1'h0;
    trig_o = 1'h0;
  end

  task automatic set_lines(input logic l1, input logic l2);
    @(posedge clk_i);
    line1_o <= l1;
    line2_o <= l2;
  endtask

  // rising edge after the given number of cycles; the bench provokes a refusal by firing soon after a line change
  task automatic fire(input int setup);
    repeat (setup) @(posedge clk_i);
    trig_o <= 1'h1;
    // lines held well past the rise so the sampled address cannot move
    repeat (25) @(posedge clk_i);
    trig_o <= 1'h0;
  endtask
endmodule

// *** bench/line_driven_parameter_set_selector_bench.sv ***
`timescale 1ns/1ps
`include "psel_cfg.svh"
module line_driven_parameter_set_selector_bench;
  typedef struct packed {
    logic [2:0] cnt;
    logic s0;
    logic s1;
    logic [1:0] inv;
    logic l1;
    logic l2;
    logic [1:0] idx;
  } psel_row_s;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, line1, line2, trig, frame_done, expo, waiting;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_rd, rd;
  logic [3:0] wb_sel;
  logic [15:0] active, got_act;
  logic [1:0] set_index, got_idx;
  int miscompares, check_count, cycles, exp_cnt, n;
  logic [15:0] sv [4] = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081};
  logic [7:0] radr [7] = '{`PSEL_OFS_CTRL, `PSEL_OFS_COUNT, `PSEL_OFS_LSRC, `PSEL_OFS_INVERT,
                           `PSEL_OFS_SLOT, `PSEL_OFS_ACTIVE, 8'h20};
  logic [2:0] rexp [7] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  psel_row_s rows [12] = '{
    '{3'h4, 1'h0, 1'h1, 2'h0, 1'h1, 1'h0, 2'h1},
    '{3'h4, 1'h0, 1'h1, 2'h0, 1'h0, 1'h1, 2'h2},
    '{3'h4, 1'h0, 1'h1, 2'h0, 1'h1, 1'h1, 2'h3},
    '{3'h4, 1'h1, 1'h0, 2'h0, 1'h1, 1'h0, 2'h2},
    '{3'h4, 1'h0, 1'h1, 2'h3, 1'h0, 1'h0, 2'h3},
    '{3'h2, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1, 2'h1},
    '{3'h2, 1'h1, 1'h0, 2'h0, 1'h0, 1'h1, 2'h1},
    '{3'h2, 1'h1, 1'h0, 2'h2, 1'h1, 1'h0, 2'h1},
    '{3'h2, 1'h1, 1'h0, 2'h0, 1'h1, 1'h0, 2'h0},
    '{3'h3, 1'h0, 1'h1, 2'h0, 1'h1, 1'h1, 2'h0},
    '{3'h2, 1'h0, 1'h0, 2'h1, 1'h0, 1'h1, 2'h1},
    '{3'h1, 1'h0, 1'h0, 2'h0, 1'h1, 1'h1, 2'h0}};

  psel_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .line1_i(line1), .line2_i(line2), .frame_trig_i(trig), .frame_done_i(frame_done),
    .active_set_o(active), .set_index_o(set_index), .exposure_start_o(expo), .waiting_trig_o(waiting)
  );
  psel_ctl_model u_ctl (.clk_i(clk_i), .line1_o(line1), .line2_o(line2), .trig_o(trig));

  initial
  begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // index and set are latched in the exposure cycle, so the load must already have landed
  always @(posedge clk_i)
  begin
    cycles++;
    if (expo === 1'h1)
    begin
      exp_cnt++;
      got_idx = set_index;
      got_act = active;
    end
    if (cycles == 6000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_i);
    // no local limit: a missing ack is caught by the cycle ceiling
    while (wb_ack !== 1'h1)
      @(posedge clk_i);
    rd = wb_rd;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic store(input logic [1:0] k, input logic [15:0] v);
    wr(`PSEL_OFS_SLOT, k);
    wr(`PSEL_OFS_ACTIVE, v);
    wr(`PSEL_OFS_STORE, 1'h1);
  endtask

  // configuration only while sequencing is off; bit 1 gets the other line
  task automatic setup(input psel_row_s r);
    wr(`PSEL_OFS_COUNT, r.cnt);
    wr(`PSEL_OFS_LSRC, {r.s0, 1'h0});
    if (r.cnt > 3'h2)
      wr(`PSEL_OFS_LSRC, {r.s1, 1'h1});
    wr(`PSEL_OFS_INVERT, r.inv);
    rdc(`PSEL_OFS_LSRC, (r.cnt > 3'h2) ? {r.s1, 1'h1} : {r.s0, 1'h0});
    wr(`PSEL_OFS_CTRL, 2'h3);
  endtask

  initial
  begin
    rst_i = 1'h1;
    {wb_cyc, wb_stb, wb_we, frame_done} = 4'h0;
    wb_adr = 8'h00;
    wb_dat = 32'h0000_0000;
    wb_sel = 4'hf;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk(active, 1'h0);
    foreach (radr[i]) rdc(radr[i], rexp[i]);
    // zero and the values five to ten must be refused, leaving the reset count
    foreach (rexp[i]) wr(`PSEL_OFS_COUNT, (i == 0) ? 32'h0000_0000 : 32'h0000_0004 + i);
    rdc(`PSEL_OFS_COUNT, 3'h4);
    wr(`PSEL_OFS_SLOT, 2'h3);
    rdc(`PSEL_OFS_SLOT, 2'h3);
    store(2'h0, 16'hdead);
    for (int k = 0; k < 4; k++) store(k[1:0], sv[k]);
    wr(`PSEL_OFS_ACTIVE, 16'h0f0f);
    foreach (rows[i])
    begin
      setup(rows[i]);
      u_ctl.set_lines(rows[i].l1, rows[i].l2);
      repeat (28) @(posedge clk_i);
      chk(waiting, 1'h1);
      n = exp_cnt;
      u_ctl.fire(2);
      chk(exp_cnt - n, 1'h1);
      chk(got_idx, rows[i].idx);
      chk(got_act, sv[rows[i].idx]);
      wr(`PSEL_OFS_CTRL, 2'h2);
      repeat (3) @(posedge clk_i);
      chk(active, sv[rows[i].idx]);
      frame_done <= 1'h1;
      @(posedge clk_i);
      frame_done <= 1'h0;
      repeat (4) @(posedge clk_i);
      chk(active, 16'h0f0f);
    end
    setup(rows[0]);
    u_ctl.set_lines(1'h0, 1'h1);
    repeat (4) @(posedge clk_i);
    chk(waiting, 1'h0);
    n = exp_cnt;
    u_ctl.fire(1);
    chk(exp_cnt - n, 1'h0);
    repeat (30) @(posedge clk_i);
    u_ctl.fire(1);
    chk(exp_cnt - n, 1'h1);
    chk(got_idx, 2'h2);
    rdc(`PSEL_OFS_STATUS, 32'h0000_0014);
    frame_done <= 1'h1;
    @(posedge clk_i);
    frame_done <= 1'h0;
    // disable while waiting, with no frame running: restore follows at once
    wr(`PSEL_OFS_CTRL, 2'h2);
    repeat (2) @(posedge clk_i);
    chk(active, 16'h0f0f);
    // sequencing on but not the line-chosen policy: the trigger must not load a set
    wr(`PSEL_OFS_CTRL, 2'h1);
    n = exp_cnt;
    u_ctl.fire(2);
    chk(exp_cnt - n, 1'h0);
    rst_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk(active, 1'h0);
    rdc(`PSEL_OFS_COUNT, 3'h4);
    print_verdict();
  end
endmodule
